/* File: bgp_ports.sv */
// two 8-bit general-purpose ports sharing pins with the external memory bus
// and with analog inputs; registers on a classic wishbone slave.
// assumes memory bus and peripheral signals come from logic on clk_i, pins
// come from outside and are synchronised here.
`timescale 1ns/10ps

module bgp_ports (
    // clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // port h pins
    input wire logic [bgp_pkg::PORT_W-1:0] h_pin_i,
    output logic [bgp_pkg::PORT_W-1:0] h_pin_o,
    output logic [bgp_pkg::PORT_W-1:0] h_pin_oe_o,
    // port j pins
    input wire logic [bgp_pkg::PORT_W-1:0] j_pin_i,
    output logic [bgp_pkg::PORT_W-1:0] j_pin_o,
    output logic [bgp_pkg::PORT_W-1:0] j_pin_oe_o,
    // external memory bus logic
    input wire logic [bgp_pkg::LOW_W-1:0] high_order_address_bits_i,
    input wire logic [bgp_pkg::PORT_W-1:0] mem_strobe_i,
    input wire logic [bgp_pkg::PORT_W-1:0] mem_strobe_oe_i,
    output logic external_bus_enabled_o,
    output logic [1:0] mem_wait_o,
    output logic [1:0] mem_mode_o,
    // peripheral overrides, bits 7:0 port h, 15:8 port j
    input wire logic [2*bgp_pkg::PORT_W-1:0] periph_en_i,
    input wire logic [2*bgp_pkg::PORT_W-1:0] periph_force_out_i,
    input wire logic [2*bgp_pkg::PORT_W-1:0] periph_dat_i,
    // analog and input threshold selection
    output logic [bgp_pkg::LOW_W-1:0] analog_channels_twelve_to_fifteen_o,
    output logic [1:0] analog_ref_cfg_o,
    output logic [bgp_pkg::LOW_W-1:0] h_low_ttl_sense_o
);
    import bgp_pkg::*;

    localparam int N = 2 * PORT_W;

    // software registers
    logic [PORT_W-1:0] h_dir_r; // RL3
    logic [PORT_W-1:0] h_lat_r;
    logic [PORT_W-1:0] j_dir_r; // RL12
    logic [PORT_W-1:0] j_lat_r;
    logic [CFG_W-1:0] acfg_r;
    logic [PORT_W-1:0] mcon_r;
    // copy of the inverted disable bit, so the enable output leaves a flip-flop directly
    logic bus_en_r;

    // bus slave state
    logic ack_r;
    logic [31:0] dat_r;

    // pin synchronisers and settled levels, bits 7:0 port h, 15:8 port j
    logic [N-1:0] sync1_r;
    logic [N-1:0] sync2_r;
    logic [N-1:0] sync3_r;
    logic [N-1:0] level_r;

    // registered pin drive
    logic [N-1:0] pin_out_r;
    logic [N-1:0] pin_oe_r;
    logic [LOW_W-1:0] analog_r;
    logic [LOW_W-1:0] ttl_r;

    // ------------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------------
    wire bus_en = ~mcon_r[MCON_EXTERNAL_BUS_DISABLE_BIT]; // RL8
    wire [LOW_W-1:0] h_up_digital = acfg_r[ACFG_DIG_LSB +: LOW_W]; // RL6
    wire [LOW_W-1:0] h_up_analog = ~h_up_digital; // RL6

    // per-pin ownership: 1 where the memory bus owns the pin
    wire [N-1:0] bus_owned;
    wire [N-1:0] analog_owned;
    wire [N-1:0] dir_all = {j_dir_r, h_dir_r};
    wire [N-1:0] lat_all = {j_lat_r, h_lat_r};
    wire [N-1:0] bus_out;
    wire [N-1:0] bus_oe;
    wire [N-1:0] out_nxt;
    wire [N-1:0] oe_nxt;

    genvar gi;
    generate
        for (gi = 0; gi < N; gi++) begin : g_pin
            if (gi < LOW_W) begin : g_h_low
                assign bus_owned[gi] = bus_en; // RL7 RL10
                assign analog_owned[gi] = 1'b0;
                assign bus_out[gi] = high_order_address_bits_i[gi]; // RL7
                assign bus_oe[gi] = 1'b1; // RL7
            end else if (gi < PORT_W) begin : g_h_up
                assign bus_owned[gi] = 1'b0;
                assign analog_owned[gi] = h_up_analog[gi-LOW_W]; // RL6 RL9
                assign bus_out[gi] = 1'b0;
                assign bus_oe[gi] = 1'b0;
            end else if (gi == PORT_W + J_FREE_BIT) begin : g_j_free
                assign bus_owned[gi] = 1'b0; // RL14
                assign analog_owned[gi] = 1'b0;
                assign bus_out[gi] = 1'b0;
                assign bus_oe[gi] = 1'b0;
            end else begin : g_j_bus
                assign bus_owned[gi] = bus_en; // RL13
                assign analog_owned[gi] = 1'b0;
                assign bus_out[gi] = mem_strobe_i[gi-PORT_W]; // RL13
                assign bus_oe[gi] = mem_strobe_oe_i[gi-PORT_W]; // RL13
            end

            // priority: memory bus, then analog (enable only), then peripheral, then port
            assign out_nxt[gi] = bus_owned[gi] ? bus_out[gi] : // RL20
                                 periph_en_i[gi] ? periph_dat_i[gi] : // RL15
                                 lat_all[gi]; // RL2
            assign oe_nxt[gi] = bus_owned[gi] ? bus_oe[gi] : // RL20
                                analog_owned[gi] ? 1'b0 : // RL6
                                periph_en_i[gi] ? periph_force_out_i[gi] : // RL15
                                ~dir_all[gi]; // RL1 RL2

            // a level counts only once the second and third stages agree
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    sync1_r[gi] <= 1'b0;
                    sync2_r[gi] <= 1'b0;
                    sync3_r[gi] <= 1'b0;
                    level_r[gi] <= 1'b0;
                end else if (ce_i) begin
                    sync1_r[gi] <= (gi < PORT_W) ? h_pin_i[gi % PORT_W] : j_pin_i[gi % PORT_W];
                    sync2_r[gi] <= sync1_r[gi];
                    sync3_r[gi] <= sync2_r[gi];
                    if (sync2_r[gi] == sync3_r[gi]) begin
                        level_r[gi] <= sync3_r[gi];
                    end
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // register read and write decode
    // ------------------------------------------------------------------
    wire req = wb_cyc_i & wb_stb_i;
    wire new_req = req & ~ack_r;
    // writes land on the edge where the master samples ack
    wire wr_commit = req & ack_r & wb_we_i & wb_sel_i[0];
    wire [7:0] wr_byte = wb_dat_i[7:0];

    wire sel_h_dir = wb_adr_i == OFF_H_DIR;
    wire sel_h_pin = wb_adr_i == OFF_H_PIN;
    wire sel_h_lat = wb_adr_i == OFF_H_LAT;
    wire sel_j_dir = wb_adr_i == OFF_J_DIR;
    wire sel_j_pin = wb_adr_i == OFF_J_PIN;
    wire sel_j_lat = wb_adr_i == OFF_J_LAT;
    wire sel_acfg = wb_adr_i == OFF_ACFG;
    wire sel_mcon = wb_adr_i == OFF_MCON;

    // analog pins read as zero; pins in bus mode still show their level
    wire [PORT_W-1:0] h_pin_rd = level_r[PORT_W-1:0] &
                                 {h_up_digital, {LOW_W{1'b1}}}; // RL9 RL19
    wire [PORT_W-1:0] j_pin_rd = level_r[N-1:PORT_W]; // RL19

    wire [7:0] rd_byte =
        sel_h_dir ? h_dir_r : // RL16
        sel_h_pin ? h_pin_rd :
        sel_h_lat ? h_lat_r : // RL4
        sel_j_dir ? j_dir_r : // RL16
        sel_j_pin ? j_pin_rd :
        sel_j_lat ? j_lat_r : // RL5
        sel_acfg ? {2'b00, acfg_r} :
        sel_mcon ? (mcon_r & MCON_MASK) :
        8'h00;

    // ------------------------------------------------------------------
    // wishbone answer: ack one cycle after the request, one cycle wide
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
            dat_r <= 32'h0000_0000;
        end else if (ce_i) begin
            ack_r <= new_req;
            if (new_req) begin
                dat_r <= {24'h00_0000, rd_byte};
            end
        end
    end

    // ------------------------------------------------------------------
    // software registers; the pin register write lands in the latch
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            h_dir_r <= RST_DIR;
            h_lat_r <= RST_LAT;
            j_dir_r <= RST_DIR; // RL17
            j_lat_r <= RST_LAT;
            acfg_r <= RST_ACFG; // RL9
            mcon_r <= RST_MCON; // RL10
            bus_en_r <= ~RST_MCON[MCON_EXTERNAL_BUS_DISABLE_BIT]; // RL10
        end else if (ce_i && wr_commit) begin
            if (sel_h_dir) begin
                h_dir_r <= wr_byte; // RL16
            end
            if (sel_h_pin || sel_h_lat) begin
                h_lat_r <= wr_byte; // RL4
            end
            if (sel_j_dir) begin
                j_dir_r <= wr_byte; // RL16
            end
            if (sel_j_pin || sel_j_lat) begin
                j_lat_r <= wr_byte; // RL5
            end
            if (sel_acfg) begin
                acfg_r <= wr_byte[CFG_W-1:0];
            end
            if (sel_mcon) begin
                mcon_r <= wr_byte & MCON_MASK;
                bus_en_r <= ~wr_byte[MCON_EXTERNAL_BUS_DISABLE_BIT]; // RL8
            end
        end
    end

    // ------------------------------------------------------------------
    // pin drive and sense selection, registered so outputs are glitch free
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_out_r <= '0;
            pin_oe_r <= '0; // RL17
            analog_r <= {LOW_W{1'b1}}; // RL9
            ttl_r <= {LOW_W{1'b1}}; // RL10 RL11
        end else if (ce_i) begin
            pin_out_r <= out_nxt;
            pin_oe_r <= oe_nxt;
            analog_r <= h_up_analog; // RL6
            ttl_r <= {LOW_W{bus_en}}; // RL11
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;
    assign h_pin_o = pin_out_r[PORT_W-1:0];
    assign h_pin_oe_o = pin_oe_r[PORT_W-1:0];
    assign j_pin_o = pin_out_r[N-1:PORT_W];
    assign j_pin_oe_o = pin_oe_r[N-1:PORT_W];
    assign analog_channels_twelve_to_fifteen_o = analog_r;
    assign h_low_ttl_sense_o = ttl_r;
    assign external_bus_enabled_o = bus_en_r;
    assign mem_wait_o = mcon_r[5:4];
    assign mem_mode_o = mcon_r[1:0];
    assign analog_ref_cfg_o = acfg_r[5:4];

endmodule : bgp_ports

/* File: bgp_pkg.sv */
// constants shared by the two bus-shared general-purpose ports
// assumes a classic wishbone slave with 32-bit data and byte addresses
//
// Function
// (RL1) direction bit one puts the pin driver in high impedance, pin is input
// (RL2) direction bit zero drives the output latch value onto the pin
// (RL3) port h has eight pins with direction, latch and pin readback each
// (RL4) reading port h latch register returns the latch, not the pins
// (RL5) port j latch register is mapped and reads back the latch
// (RL6) port h pins 4..7 are digital or analog channels 12..15 per analog config
// (RL7) with external bus enabled, port h pins 0..3 drive address bits 16..19
// (RL8) memory bus control, not direction bits, picks port h low pin function
// (RL9) after reset port h upper pins are analog and read as zero
// (RL10) after reset port h lower pins carry the system bus address
// (RL11) lower pins sense schmitt in io mode, ttl in bus mode; upper always schmitt
// (RL12) port j has eight pins with direction, latch and pin readback each
// (RL13) port j is plain io only with bus disabled, else drives memory strobes
// (RL14) port j bit 5 stays under port control even with the bus enabled
// (RL15) an enabled peripheral may force a pin to output or input
// (RL16) peripheral overrides never alter the direction register contents
// (RL17) after reset every port j pin is a digital input; here reset enables the bus, so all but bit 5 take the memory strobe enables
// (RL18) software should preset direction bits before enabling a peripheral
// (RL19) pin register reads sampled levels, zero for analog pins
// (RL20) pins owned by the system bus take value and enable from bus logic

package bgp_pkg;

    localparam int PORT_W = 8;
    localparam int LOW_W = 4;
    localparam int CFG_W = 6;

    // register byte offsets
    localparam logic [7:0] OFF_H_DIR = 8'h00;
    localparam logic [7:0] OFF_H_PIN = 8'h04;
    localparam logic [7:0] OFF_H_LAT = 8'h08;
    localparam logic [7:0] OFF_J_DIR = 8'h0C;
    localparam logic [7:0] OFF_J_PIN = 8'h10;
    localparam logic [7:0] OFF_J_LAT = 8'h14;
    localparam logic [7:0] OFF_ACFG = 8'h18;
    localparam logic [7:0] OFF_MCON = 8'h1C;

    // values after reset
    localparam logic [7:0] RST_DIR = 8'hFF;
    localparam logic [7:0] RST_LAT = 8'h00;
    localparam logic [5:0] RST_ACFG = 6'h00;
    localparam logic [7:0] RST_MCON = 8'h00;

    // memory_bus_control layout: bit 7 external_bus_disable, wait 5:4, mode 1:0
    localparam int MCON_EXTERNAL_BUS_DISABLE_BIT = 7;
    localparam logic [7:0] MCON_MASK = 8'hB3;

    // analog_pin_config: bits 3:0 turn port h pins 4..7 digital, bits 5:4 reference
    localparam int ACFG_DIG_LSB = 0;

    // port j pin that never belongs to the memory bus
    localparam int J_FREE_BIT = 5;

    // synchroniser depth for pin inputs
    localparam int SYNC_D = 3;

endpackage : bgp_pkg

/* File: bgp_ports_assertions.sv */
// checker for the bus-shared ports: pin drive, pin mode and reset relations
// assumes it is bound to bgp_ports and sees its ports under the same names
`timescale 1ns/10ps

module bgp_ports_assertions (
    // clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // wishbone
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_o,
    // pins
    input wire logic [7:0] h_pin_o,
    input wire logic [7:0] h_pin_oe_o,
    input wire logic [7:0] j_pin_o,
    input wire logic [7:0] j_pin_oe_o,
    // bus, peripheral and mode signals
    input wire logic [3:0] high_order_address_bits_i,
    input wire logic [7:0] mem_strobe_i,
    input wire logic [7:0] mem_strobe_oe_i,
    input wire logic external_bus_enabled_o,
    input wire logic [15:0] periph_en_i,
    input wire logic [15:0] periph_force_out_i,
    input wire logic [15:0] periph_dat_i,
    input wire logic [3:0] analog_channels_twelve_to_fifteen_o,
    input wire logic [3:0] h_low_ttl_sense_o
);
    import bgp_pkg::*;
    logic [7:0] j_dir_r;
    logic j_dir_wr;
    // shadow of the direction register, written where the master samples ack
    assign j_dir_wr = wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == OFF_J_DIR;
    always_ff @(posedge clk_i) begin
        if (rst_i) j_dir_r <= RST_DIR;
        else if (j_dir_wr) j_dir_r <= wb_dat_i[7:0];
    end
    // the edge that releases reset still shows reset values on the outputs
    logic rst_d_r;
    always_ff @(posedge clk_i) rst_d_r <= rst_i;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i || rst_d_r);
    a_addr_on_low: assert property (
        external_bus_enabled_o && ce_i |=> h_pin_oe_o[3:0] == 4'hf
            && h_pin_o[3:0] == $past(high_order_address_bits_i)) else $error("address pins");
    a_strobes_on_j: assert property (
        external_bus_enabled_o && ce_i |=> (j_pin_oe_o & 8'hdf) == ($past(mem_strobe_oe_i) & 8'hdf)
            && (j_pin_o & 8'hdf) == ($past(mem_strobe_i) & 8'hdf)) else $error("strobe pins");
    a_free_forced_out: assert property (
        periph_en_i[13] && periph_force_out_i[13] && ce_i |=> j_pin_oe_o[5]
            && j_pin_o[5] == $past(periph_dat_i[13])) else $error("forced output");
    a_free_forced_in: assert property (
        periph_en_i[13] && !periph_force_out_i[13] && ce_i |=> !j_pin_oe_o[5])
        else $error("forced input");
    a_analog_quiet: assert property (
        ce_i |=> (h_pin_oe_o[7:4] & $past(analog_channels_twelve_to_fifteen_o)
            & analog_channels_twelve_to_fifteen_o) == 4'h0) else $error("analog pin driven");
    a_ttl_follows_bus: assert property (
        ce_i |-> ##[0:1] h_low_ttl_sense_o == {4{external_bus_enabled_o}})
        else $error("threshold");
    a_reset_values: assert property (disable iff (1'b0)
        rst_i |=> j_pin_oe_o == 8'h00 && h_pin_oe_o == 8'h00 && external_bus_enabled_o
            && analog_channels_twelve_to_fifteen_o == 4'hf) else $error("reset state");
    a_dir_drives_oe: assert property (
        !external_bus_enabled_o && periph_en_i[15:8] == 8'h00 && ce_i
            |=> j_pin_oe_o == ~$past(j_dir_r)) else $error("direction drive");
endmodule : bgp_ports_assertions

/* File: bgp_board_model.sv */
// board side of both ports: drives every pin that the block leaves free
// assumes oe high while the block drives; the board has no pulls
`timescale 1ns/10ps

module bgp_board_model (
    // block side
    input wire logic [7:0] h_pin_o,
    input wire logic [7:0] h_pin_oe_o,
    input wire logic [7:0] j_pin_o,
    input wire logic [7:0] j_pin_oe_o,
    // board drive values
    input wire logic [7:0] h_board_i,
    input wire logic [7:0] j_board_i,
    // resolved pin levels
    output logic [7:0] h_pin_i,
    output logic [7:0] j_pin_i
);
    // board lets go wherever the block drives, so the wire never fights
    assign h_pin_i = (h_pin_o & h_pin_oe_o) | (h_board_i & ~h_pin_oe_o);
    assign j_pin_i = (j_pin_o & j_pin_oe_o) | (j_board_i & ~j_pin_oe_o);
endmodule : bgp_board_model

/* File: bgp_ports_tb.sv */
// self-checking bench for the bus-shared ports
// assumes the board model resolves pins; read results are checked from a queue
`timescale 1ns/10ps

`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin mismatches++; \
    $display("MISMATCH %0t got %h want %h", $time, a, b); end end

module bgp_ports_tb;
    import bgp_pkg::*;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0, ack;
    logic [7:0] adr = 8'h00, hpo, hoe, jpo, joe, hpi, jpi, d, l;
    logic [7:0] stb = 8'h00, stb_oe = 8'h00, hb = 8'h00, jb = 8'h00;
    logic [3:0] hob = 4'h0;
    logic [15:0] p_en = 16'h0000, p_out = 16'h0000, p_dat = 16'h0000;
    logic [31:0] wdat = 32'h0000_0000, rdat, want;
    logic [31:0] exp_q[$];
    logic ebo;
    logic [1:0] mwait, mmode, aref;
    int mismatches = 0, n_checks = 0;

    bgp_ports bgp_ports_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc),
        .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .h_pin_i(hpi), .h_pin_o(hpo), .h_pin_oe_o(hoe),
        .j_pin_i(jpi), .j_pin_o(jpo), .j_pin_oe_o(joe), .high_order_address_bits_i(hob),
        .mem_strobe_i(stb), .mem_strobe_oe_i(stb_oe), .external_bus_enabled_o(ebo),
        .mem_wait_o(mwait), .mem_mode_o(mmode), .periph_en_i(p_en), .periph_force_out_i(p_out),
        .periph_dat_i(p_dat), .analog_channels_twelve_to_fifteen_o(), .analog_ref_cfg_o(aref),
        .h_low_ttl_sense_o());
    bgp_board_model bgp_board_model_inst (.h_pin_o(hpo), .h_pin_oe_o(hoe), .j_pin_o(jpo),
        .j_pin_oe_o(joe), .h_board_i(hb), .j_board_i(jb), .h_pin_i(hpi), .j_pin_i(jpi));

    task automatic results;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : results

    // one classic cycle; a read notes its expected byte in the queue
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] v);
        int n;
        n = 0;
        if (!w) exp_q.push_back({24'h00_0000, v});
        @(posedge clk_i);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h00_0000, v};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (ack !== 1'b1) begin
            mismatches++;
            $display("MISMATCH %0t no ack", $time);
            results();
        end
        cyc <= 1'b0;
    endtask : wb

    always @(posedge clk_i) begin
        if (ack === 1'b1 && we === 1'b0) begin
            if (exp_q.size() == 0) begin
                mismatches++;
                $display("MISMATCH %0t read with nothing expected", $time);
            end else begin
                want = exp_q.pop_front();
                `CHK(rdat, want)
            end
        end
    end

    initial begin
        forever #20 clk_i = ~clk_i;
    end

    initial begin
        void'($urandom(32'h5a28));
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        hob <= 4'($urandom);
        stb <= 8'($urandom);
        stb_oe <= 8'($urandom);
        hb <= 8'($urandom);
        repeat (6) @(posedge clk_i);
        wb(0, OFF_H_DIR, RST_DIR);
        wb(0, OFF_J_DIR, RST_DIR);
        wb(0, OFF_H_PIN, {4'h0, hob});
        l = 8'($urandom);
        wb(1, OFF_H_LAT, l);
        wb(0, OFF_H_LAT, l);
        wb(1, OFF_MCON, 8'hff);
        wb(0, OFF_MCON, MCON_MASK);
        `CHK({ebo, mwait, mmode}, 5'h0f)
        wb(1, OFF_ACFG, 8'h3f);
        wb(0, OFF_ACFG, 8'h3f);
        `CHK(aref, 2'h3)
        wb(1, OFF_H_DIR, 8'h0f);
        repeat (6) @(posedge clk_i);
        wb(0, OFF_H_PIN, {l[7:4], hb[3:0]});
        for (int i = 0; i < 4; i++) begin
            d = 8'($urandom);
            l = 8'($urandom);
            jb <= 8'($urandom);
            wb(1, OFF_J_DIR, d);
            wb(1, OFF_J_PIN, l);
            repeat (6) @(posedge clk_i);
            wb(0, OFF_J_LAT, l);
            wb(0, OFF_J_PIN, (l & ~d) | (jb & d));
        end
        d[5] = 1'b0;
        wb(1, OFF_J_DIR, d);
        p_dat <= 16'($urandom);
        p_en <= 16'h2000;
        p_out <= 16'h2000;
        repeat (6) @(posedge clk_i);
        wb(0, OFF_J_DIR, d);
        wb(0, OFF_J_PIN, (((l & ~d) | (jb & d)) & 8'hdf) | {2'b00, p_dat[13], 5'h00});
        p_out <= 16'h0000;
        wb(1, 8'h20, 8'ha5);
        wb(0, 8'h20, 8'h00);
        wb(1, OFF_ACFG, 8'h00);
        wb(1, OFF_MCON, 8'h00);
        repeat (6) @(posedge clk_i);
        wb(0, OFF_H_PIN, {4'h0, hob});
        `CHK({ebo, mwait, mmode}, 5'h10)
        results();
    end
endmodule : bgp_ports_tb

bind bgp_ports bgp_ports_assertions bgp_ports_assertions_inst (.*);
